// *** design/atp_pkg.sv ***
/*
 * Package: register map, fields, reset values and rate codes.
 * Assumes AXI4-Lite, 32-bit data, byte addresses.
 */
package atp_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam int unsigned ADDR_W            = 8;
    localparam logic [7:0]  OFF_RATE_CONFIG   = 8'h64;
    localparam logic [7:0]  OFF_PATH_CONFIG   = 8'h68;
    localparam logic [7:0]  OFF_INPUT_MODE    = 8'h6c;
    localparam logic [7:0]  OFF_APLL_SOURCE   = 8'h70;
    localparam logic [7:0]  OFF_OUTPUT_ENABLE = 8'h74;
    localparam logic [7:0]  OFF_STATUS        = 8'h78;

    // ==========================================================
    // Rate configuration register fields
    // ==========================================================
    localparam int unsigned BIT_FAIL_SQUELCH  = 6;
    localparam int unsigned BIT_DUTY_SELECT   = 5;
    localparam int unsigned BIT_BITS_RATE     = 4;
    localparam int unsigned RATE_LSB          = 0;
    localparam int unsigned RATE_W            = 3;
    localparam logic [7:0]  RATE_CONFIG_RST   = 8'h01;
    localparam logic [7:0]  RATE_CONFIG_WMASK = 8'h77;

    // ==========================================================
    // Other configuration fields
    // ==========================================================
    localparam int unsigned BIT_FROM_MAIN     = 0;
    localparam int unsigned BIT_FAMILY        = 0;
    localparam int unsigned BIT_APLL_SRC      = 0;
    localparam int unsigned BIT_CC_EN         = 0;
    localparam int unsigned BIT_BITS_EN       = 1;
    localparam logic        FROM_MAIN_RST     = 1'b0;
    localparam logic        APLL_SRC_RST      = 1'b0;
    localparam logic [1:0]  OUTPUT_EN_RST     = 2'h3;

    // Status bits
    localparam int unsigned ST_INPUT_FAIL     = 0;
    localparam int unsigned ST_CC_ACTIVE      = 1;
    localparam int unsigned ST_BITS_ACTIVE    = 2;
    localparam int unsigned ST_DPLL_RUN       = 3;
    localparam int unsigned ST_BITS_SONET     = 4;
    localparam int unsigned ST_APLL_FED       = 5;

    // ==========================================================
    // AXI responses
    // ==========================================================
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    // ==========================================================
    // Digital PLL rate codes
    // ==========================================================
    typedef enum logic [2:0] {
        ATP_RATE_SQUELCH = 3'h0,
        ATP_RATE_OCN     = 3'h1,
        ATP_RATE_12E1    = 3'h2,
        ATP_RATE_16E1    = 3'h3,
        ATP_RATE_24DS1   = 3'h4,
        ATP_RATE_16DS1   = 3'h5,
        ATP_RATE_E3      = 3'h6,
        ATP_RATE_DS3     = 3'h7
    } atp_rate_t;

    // Analogue PLL output before dividers, in kHz
    localparam logic [18:0] APLL_KHZ_OFF      = 19'h00000;
    localparam logic [18:0] APLL_KHZ_OCN      = 19'd311040;
    localparam logic [18:0] APLL_KHZ_12E1     = 19'd98304;
    localparam logic [18:0] APLL_KHZ_16E1     = 19'd131072;
    localparam logic [18:0] APLL_KHZ_24DS1    = 19'd148224;
    localparam logic [18:0] APLL_KHZ_16DS1    = 19'd98816;
    localparam logic [18:0] APLL_KHZ_E3       = 19'd274944;
    localparam logic [18:0] APLL_KHZ_DS3      = 19'd178944;

endpackage

// *** design/atp_cfg_if.sv ***
/*
 * Rate setting out to the decoder, PLL controls back.
 * Assumes one shared clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface atp_cfg_if;
    logic [2:0]  rate_field;
    logic        apll_src_main;
    logic        dpll_enable;
    logic [2:0]  dpll_mode;
    logic        apll_input_enable;
    logic        apll_from_main;
    logic [18:0] apll_freq_khz;

    modport ctrl (
        output rate_field,
        output apll_src_main,
        input  dpll_enable,
        input  dpll_mode,
        input  apll_input_enable,
        input  apll_from_main,
        input  apll_freq_khz
    );

    modport dec (
        input  rate_field,
        input  apll_src_main,
        output dpll_enable,
        output dpll_mode,
        output apll_input_enable,
        output apll_from_main,
        output apll_freq_khz
    );
endinterface

`default_nettype wire

// *** design/atp_rate_decoder.sv ***
/*
 * Registered decode of the aux PLL rate field.
 * Assumes one clock, sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module atp_rate_decoder (
    input  wire logic sys_clk_i,
    input  wire logic arst_n_i,
    atp_cfg_if.dec    cfg
);

    // ==========================================================
    // Lookup
    // ==========================================================
    logic [18:0] freq_nxt;

    always_comb begin
        case (cfg.rate_field)
            atp_pkg::ATP_RATE_SQUELCH: freq_nxt = atp_pkg::APLL_KHZ_OFF;
            atp_pkg::ATP_RATE_OCN:     freq_nxt = atp_pkg::APLL_KHZ_OCN;
            atp_pkg::ATP_RATE_12E1:    freq_nxt = atp_pkg::APLL_KHZ_12E1;
            atp_pkg::ATP_RATE_16E1:    freq_nxt = atp_pkg::APLL_KHZ_16E1;
            atp_pkg::ATP_RATE_24DS1:   freq_nxt = atp_pkg::APLL_KHZ_24DS1;
            atp_pkg::ATP_RATE_16DS1:   freq_nxt = atp_pkg::APLL_KHZ_16DS1;
            atp_pkg::ATP_RATE_E3:      freq_nxt = atp_pkg::APLL_KHZ_E3;
            atp_pkg::ATP_RATE_DS3:     freq_nxt = atp_pkg::APLL_KHZ_DS3;
            default:                   freq_nxt = atp_pkg::APLL_KHZ_OFF;
        endcase
        // Main-fed rate is set elsewhere
        if (cfg.apll_src_main) begin
            freq_nxt = atp_pkg::APLL_KHZ_OFF;
        end
    end

    // ==========================================================
    // Registered controls
    // ==========================================================
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg.dpll_enable       <= 1'b1;
            cfg.dpll_mode         <= atp_pkg::ATP_RATE_OCN;
            cfg.apll_input_enable <= 1'b1;
            cfg.apll_from_main    <= 1'b0;
            cfg.apll_freq_khz     <= atp_pkg::APLL_KHZ_OCN;
        end else begin
            cfg.dpll_enable       <= (cfg.rate_field != atp_pkg::ATP_RATE_SQUELCH);
            cfg.dpll_mode         <= cfg.rate_field;
            // Squelch cuts the input, any source
            cfg.apll_input_enable <= (cfg.rate_field != atp_pkg::ATP_RATE_SQUELCH);
            cfg.apll_from_main    <= cfg.apll_src_main;
            cfg.apll_freq_khz     <= freq_nxt;
        end
    end

endmodule

`default_nettype wire

// *** design/atp_rate_config.sv ***
/*
 * Aux timing path rate configuration: AXI4-Lite slave,
 * output squelch and BITS rate steering,
 * aux PLL rate control via the decoder.
 * Assumes inputs on sys_clk_i and one
 * outstanding AXI4-Lite access.
 */
// Implementation choice: the AXI4-Lite slave port.

`timescale 1ns/1ps
`default_nettype none

module atp_rate_config (
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic [2:0]  s_axi_awprot_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic [2:0]  s_axi_arprot_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // Device side
    input  wire logic        rate_family_preset_i,
    input  wire logic        aux_inputs_failed_i,
    output logic             composite_clock_enable_o,
    output logic             composite_clock_duty_5of8_o,
    output logic             bits_output_enable_o,
    output logic             bits_rate_sonet_o,
    output logic             aux_dpll_enable_o,
    output logic [2:0]       aux_dpll_mode_o,
    output logic             aux_apll_input_enable_o,
    output logic             aux_apll_from_main_o,
    output logic [18:0]      aux_apll_freq_khz_o
);

    // ==========================================================
    // Configuration state
    // ==========================================================
    logic [7:0] rate_cfg_r;
    logic       from_main_r;
    logic       family_r;
    logic       apll_src_r;
    logic [1:0] out_en_r;
    logic       preset_done_r;

    // ==========================================================
    // Write channel
    // ==========================================================
    typedef enum logic [1:0] {
        ATP_WS_COLLECT = 2'b01,
        ATP_WS_RESP    = 2'b10
    } atp_wstate_t;

    atp_wstate_t wstate_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  waddr_r;
    logic [31:0] wdata_r;
    logic        wlane0_r;
    logic [1:0]  bresp_r;
    logic        aw_fire;
    logic        w_fire;
    logic        wr_do;
    logic        wr_hit;

    assign s_axi_awready_o = (wstate_r == ATP_WS_COLLECT) && !aw_got_r;
    assign s_axi_wready_o  = (wstate_r == ATP_WS_COLLECT) && !w_got_r;
    assign aw_fire         = s_axi_awvalid_i && s_axi_awready_o;
    assign w_fire          = s_axi_wvalid_i && s_axi_wready_o;
    assign wr_do           = (wstate_r == ATP_WS_COLLECT) && aw_got_r && w_got_r;
    assign s_axi_bvalid_o  = (wstate_r == ATP_WS_RESP);
    assign s_axi_bresp_o   = bresp_r;

    always_comb begin
        case (waddr_r)
            atp_pkg::OFF_RATE_CONFIG,
            atp_pkg::OFF_PATH_CONFIG,
            atp_pkg::OFF_INPUT_MODE,
            atp_pkg::OFF_APLL_SOURCE,
            atp_pkg::OFF_OUTPUT_ENABLE,
            atp_pkg::OFF_STATUS:        wr_hit = 1'b1;
            default:                    wr_hit = 1'b0;
        endcase
    end

    // AW and W in either order
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            waddr_r  <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wlane0_r <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_got_r <= 1'b1;
                waddr_r  <= {s_axi_awaddr_i[7:2], 2'b00};
            end
            if (w_fire) begin
                w_got_r  <= 1'b1;
                wdata_r  <= s_axi_wdata_i;
                wlane0_r <= s_axi_wstrb_i[0];
            end
            if (wr_do) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wstate_r <= ATP_WS_COLLECT;
            bresp_r  <= atp_pkg::RESP_OKAY;
        end else begin
            case (wstate_r)
                ATP_WS_COLLECT: begin
                    if (wr_do) begin
                        wstate_r <= ATP_WS_RESP;
                        bresp_r  <= wr_hit ? atp_pkg::RESP_OKAY : atp_pkg::RESP_SLVERR;
                    end
                end
                ATP_WS_RESP: begin
                    if (s_axi_bready_i) begin
                        wstate_r <= ATP_WS_COLLECT;
                    end
                end
                default: begin
                    wstate_r <= ATP_WS_COLLECT;
                end
            endcase
        end
    end

    // ==========================================================
    // Register updates
    // ==========================================================
    logic wr_lane;

    // Only byte lane 0 carries register bits
    assign wr_lane = wr_do && wlane0_r;

    // Preset is sampled after release, not at reset
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            preset_done_r <= 1'b0;
        end else begin
            preset_done_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rate_cfg_r <= atp_pkg::RATE_CONFIG_RST;
        end else if (!preset_done_r) begin
            rate_cfg_r[atp_pkg::BIT_BITS_RATE] <= rate_family_preset_i;
        end else if (wr_lane && waddr_r == atp_pkg::OFF_RATE_CONFIG) begin
            rate_cfg_r <= wdata_r[7:0] & atp_pkg::RATE_CONFIG_WMASK;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            family_r <= 1'b0;
        end else if (!preset_done_r) begin
            family_r <= rate_family_preset_i;
        end else if (wr_lane && waddr_r == atp_pkg::OFF_INPUT_MODE) begin
            family_r <= wdata_r[atp_pkg::BIT_FAMILY];
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            from_main_r <= atp_pkg::FROM_MAIN_RST;
            apll_src_r  <= atp_pkg::APLL_SRC_RST;
            out_en_r    <= atp_pkg::OUTPUT_EN_RST;
        end else if (wr_lane) begin
            if (waddr_r == atp_pkg::OFF_PATH_CONFIG) begin
                from_main_r <= wdata_r[atp_pkg::BIT_FROM_MAIN];
            end
            if (waddr_r == atp_pkg::OFF_APLL_SOURCE) begin
                apll_src_r <= wdata_r[atp_pkg::BIT_APLL_SRC];
            end
            if (waddr_r == atp_pkg::OFF_OUTPUT_ENABLE) begin
                out_en_r <= {wdata_r[atp_pkg::BIT_BITS_EN], wdata_r[atp_pkg::BIT_CC_EN]};
            end
        end
    end

    // ==========================================================
    // Output steering
    // ==========================================================
    logic squelch_now;
    logic cc_en_nxt;
    logic bits_en_nxt;
    logic sonet_nxt;

    always_comb begin
        squelch_now = rate_cfg_r[atp_pkg::BIT_FAIL_SQUELCH] && aux_inputs_failed_i;
        cc_en_nxt   = out_en_r[atp_pkg::BIT_CC_EN] && !squelch_now;
        bits_en_nxt = out_en_r[atp_pkg::BIT_BITS_EN] && !squelch_now;
        if (from_main_r) begin
            sonet_nxt = family_r;
        end else begin
            sonet_nxt = rate_cfg_r[atp_pkg::BIT_BITS_RATE];
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            composite_clock_enable_o    <= 1'b0;
            bits_output_enable_o        <= 1'b0;
            composite_clock_duty_5of8_o <= 1'b0;
            bits_rate_sonet_o           <= 1'b0;
        end else begin
            composite_clock_enable_o    <= cc_en_nxt;
            bits_output_enable_o        <= bits_en_nxt;
            composite_clock_duty_5of8_o <= rate_cfg_r[atp_pkg::BIT_DUTY_SELECT];
            bits_rate_sonet_o           <= sonet_nxt;
        end
    end

    // ==========================================================
    // PLL rate control
    // ==========================================================
    atp_cfg_if cfg_bus ();

    assign cfg_bus.rate_field    = rate_cfg_r[atp_pkg::RATE_LSB +: atp_pkg::RATE_W];
    assign cfg_bus.apll_src_main = apll_src_r;

    atp_rate_decoder u_decoder (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .cfg       (cfg_bus.dec)
    );

    assign aux_dpll_enable_o       = cfg_bus.dpll_enable;
    assign aux_dpll_mode_o         = cfg_bus.dpll_mode;
    assign aux_apll_input_enable_o = cfg_bus.apll_input_enable;
    assign aux_apll_from_main_o    = cfg_bus.apll_from_main;
    assign aux_apll_freq_khz_o     = cfg_bus.apll_freq_khz;

    // ==========================================================
    // Read channel
    // ==========================================================
    typedef enum logic [1:0] {
        ATP_RS_IDLE = 2'b01,
        ATP_RS_DATA = 2'b10
    } atp_rstate_t;

    atp_rstate_t rstate_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [7:0]  rd_addr;

    assign rd_addr         = {s_axi_araddr_i[7:2], 2'b00};
    assign s_axi_arready_o = (rstate_r == ATP_RS_IDLE);
    assign s_axi_rvalid_o  = (rstate_r == ATP_RS_DATA);
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (rd_addr)
            atp_pkg::OFF_RATE_CONFIG:   rd_word[7:0] = rate_cfg_r;
            atp_pkg::OFF_PATH_CONFIG:   rd_word[atp_pkg::BIT_FROM_MAIN] = from_main_r;
            atp_pkg::OFF_INPUT_MODE:    rd_word[atp_pkg::BIT_FAMILY] = family_r;
            atp_pkg::OFF_APLL_SOURCE:   rd_word[atp_pkg::BIT_APLL_SRC] = apll_src_r;
            atp_pkg::OFF_OUTPUT_ENABLE: rd_word[1:0] = out_en_r;
            atp_pkg::OFF_STATUS: begin
                rd_word[atp_pkg::ST_INPUT_FAIL]  = aux_inputs_failed_i;
                rd_word[atp_pkg::ST_CC_ACTIVE]   = composite_clock_enable_o;
                rd_word[atp_pkg::ST_BITS_ACTIVE] = bits_output_enable_o;
                rd_word[atp_pkg::ST_DPLL_RUN]    = cfg_bus.dpll_enable;
                rd_word[atp_pkg::ST_BITS_SONET]  = bits_rate_sonet_o;
                rd_word[atp_pkg::ST_APLL_FED]    = cfg_bus.apll_input_enable;
            end
            default:                    rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rstate_r <= ATP_RS_IDLE;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= atp_pkg::RESP_OKAY;
        end else begin
            case (rstate_r)
                ATP_RS_IDLE: begin
                    if (s_axi_arvalid_i) begin
                        rstate_r <= ATP_RS_DATA;
                        rdata_r  <= rd_word;
                        rresp_r  <= rd_hit ? atp_pkg::RESP_OKAY : atp_pkg::RESP_SLVERR;
                    end
                end
                ATP_RS_DATA: begin
                    if (s_axi_rready_i) begin
                        rstate_r <= ATP_RS_IDLE;
                    end
                end
                default: begin
                    rstate_r <= ATP_RS_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// *** verif/atp_rate_config_monitor.sv ***
/*
 * Checker of PLL control and squelch outputs.
 * Assumes a bind onto atp_rate_config, one clock.
 */
`timescale 1ns/1ps
`default_nettype none

module atp_rate_config_monitor (
    input wire logic        sys_clk_i,
    input wire logic        arst_n_i,
    input wire logic        aux_inputs_failed_i,
    input wire logic        composite_clock_enable_o,
    input wire logic        bits_output_enable_o,
    input wire logic        aux_dpll_enable_o,
    input wire logic [2:0]  aux_dpll_mode_o,
    input wire logic        aux_apll_input_enable_o,
    input wire logic        aux_apll_from_main_o,
    input wire logic [18:0] aux_apll_freq_khz_o
);
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Failure onset never brings an output up
    sequence s_fail_rise;
        $rose(aux_inputs_failed_i);
    endsequence
    a_fail_no_rise: assert property (s_fail_rise |=> !$rose(composite_clock_enable_o)
        && !$rose(bits_output_enable_o)) else $error("rise on fail");
    a_dpll_off: assert property (aux_dpll_mode_o == 3'h0 |-> !aux_dpll_enable_o)
        else $error("dpll not squelched");
    a_dpll_run: assert property (aux_dpll_mode_o != 3'h0 |-> aux_dpll_enable_o)
        else $error("dpll squelched");
    a_apll_cut: assert property (!aux_dpll_enable_o |-> !aux_apll_input_enable_o)
        else $error("apll fed");
    a_apll_fed: assert property (aux_dpll_enable_o |-> aux_apll_input_enable_o)
        else $error("apll cut");
    a_freq_ocn: assert property (aux_dpll_mode_o == 3'h1 && !aux_apll_from_main_o
        |-> aux_apll_freq_khz_o == atp_pkg::APLL_KHZ_OCN) else $error("ocn freq");
    a_freq_e3: assert property (aux_dpll_mode_o == 3'h6 && !aux_apll_from_main_o
        |-> aux_apll_freq_khz_o == atp_pkg::APLL_KHZ_E3) else $error("e3 freq");
    a_freq_main: assert property (aux_apll_from_main_o |-> aux_apll_freq_khz_o == 19'h0)
        else $error("freq from main");
endmodule

bind atp_rate_config atp_rate_config_monitor u_mon (.sys_clk_i, .arst_n_i,
    .aux_inputs_failed_i, .composite_clock_enable_o, .bits_output_enable_o,
    .aux_dpll_enable_o, .aux_dpll_mode_o, .aux_apll_input_enable_o,
    .aux_apll_from_main_o, .aux_apll_freq_khz_o);

`default_nettype wire

// *** verif/test_atp_rate_config.sv ***
/*
 * Bench for the rate configuration block over AXI4-Lite.
 * Assumes one-edge output lag.
 */
`timescale 1ns/1ps
`default_nettype none

module test_atp_rate_config;
    // ==========================================================
    // Signals
    // ==========================================================
    logic        sys_clk_i = 0, arst_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
    logic        s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic        rate_family_preset_i = 1, aux_inputs_failed_i = 0;
    logic [7:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
    logic [2:0]  aux_dpll_mode_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp;
    logic [18:0] aux_apll_freq_khz_o;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic        s_axi_rvalid_o, composite_clock_enable_o, composite_clock_duty_5of8_o;
    logic        bits_output_enable_o, bits_rate_sonet_o, aux_dpll_enable_o;
    logic        aux_apll_input_enable_o, aux_apll_from_main_o;
    logic [31:0] q;
    int          n_errors = 0, comparisons = 0;
    localparam logic [18:0] FT [8] = '{atp_pkg::APLL_KHZ_OFF, atp_pkg::APLL_KHZ_OCN,
        atp_pkg::APLL_KHZ_12E1, atp_pkg::APLL_KHZ_16E1, atp_pkg::APLL_KHZ_24DS1,
        atp_pkg::APLL_KHZ_16DS1, atp_pkg::APLL_KHZ_E3, atp_pkg::APLL_KHZ_DS3};

    atp_rate_config dut (.sys_clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awprot_i(3'h0),
        .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arprot_i(3'h0), .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .rate_family_preset_i, .aux_inputs_failed_i, .composite_clock_enable_o,
        .composite_clock_duty_5of8_o, .bits_output_enable_o, .bits_rate_sonet_o,
        .aux_dpll_enable_o, .aux_dpll_mode_o, .aux_apll_input_enable_o,
        .aux_apll_from_main_o, .aux_apll_freq_khz_o);

    always #12.5 sys_clk_i = ~sys_clk_i;

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Readies sampled mid-cycle
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, h1, h2, v;
        int n;
        pa = 1;
        pw = w;
        v = 0;
        n = 0;
        @(posedge sys_clk_i);
        s_axi_awaddr_i <= a;
        s_axi_araddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_bready_i <= w;
        s_axi_rready_i <= !w;
        while (!v && n < 40) begin
            s_axi_awvalid_i <= w && pa;
            s_axi_wvalid_i <= pw;
            s_axi_arvalid_i <= !w && pa;
            @(negedge sys_clk_i);
            h1 = pa && (w ? s_axi_awready_o : s_axi_arready_o);
            h2 = pw && s_axi_wready_o;
            v = !pa && !pw && (w ? s_axi_bvalid_o : s_axi_rvalid_o);
            q = s_axi_rdata_o;
            rsp = w ? s_axi_bresp_o : s_axi_rresp_o;
            @(posedge sys_clk_i);
            if (h1) pa = 0;
            if (h2) pw = 0;
            n++;
        end
        s_axi_bready_i <= 0;
        s_axi_rready_i <= 0;
        chk("answer", 32'h1, {31'h0, v});
    endtask

    task automatic wc(input logic [7:0] a, input logic [31:0] d);
        axi(1, a, d);
        chk("bresp", atp_pkg::RESP_OKAY, rsp);
        repeat (2) @(posedge sys_clk_i);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset;
        axi(0, 8'h64, 0);
        chk("rate reset", 32'h11, q);
        chk("sonet reset", 1, bits_rate_sonet_o);
    endtask

    task automatic t_rates;
        for (int i = 0; i < 8; i++) begin
            wc(8'h64, i);
            chk("mode", i, aux_dpll_mode_o);
            chk("dpll en", i != 0, aux_dpll_enable_o);
            chk("apll en", i != 0, aux_apll_input_enable_o);
            chk("freq", FT[i], aux_apll_freq_khz_o);
        end
    endtask

    task automatic t_bits;
        wc(8'h64, 32'hff);
        axi(0, 8'h64, 0);
        chk("unused", 32'h77, q);
        chk("duty", 1, composite_clock_duty_5of8_o);
        chk("sonet", 1, bits_rate_sonet_o);
        wc(8'h64, 32'h01);
        chk("duty", 0, composite_clock_duty_5of8_o);
        chk("sonet", 0, bits_rate_sonet_o);
    endtask

    task automatic t_path;
        wc(8'h68, 1);
        wc(8'h6c, 1);
        chk("family", 1, bits_rate_sonet_o);
        wc(8'h64, 32'h11);
        wc(8'h6c, 0);
        chk("family", 0, bits_rate_sonet_o);
        wc(8'h68, 0);
        chk("own bit", 1, bits_rate_sonet_o);
        wc(8'h64, 32'h01);
    endtask

    task automatic t_fail;
        aux_inputs_failed_i <= 1;
        wc(8'h64, 32'h41);
        chk("cc off", 0, composite_clock_enable_o);
        chk("bits off", 0, bits_output_enable_o);
        wc(8'h64, 32'h01);
        chk("cc on", 1, composite_clock_enable_o);
        chk("bits on", 1, bits_output_enable_o);
        aux_inputs_failed_i <= 0;
    endtask

    task automatic t_src;
        wc(8'h70, 1);
        chk("from main", 1, aux_apll_from_main_o);
        chk("freq main", 0, aux_apll_freq_khz_o);
        wc(8'h70, 0);
        chk("freq own", atp_pkg::APLL_KHZ_OCN, aux_apll_freq_khz_o);
        axi(0, 8'h80, 0);
        chk("unmapped", atp_pkg::RESP_SLVERR, rsp);
    endtask

    // ==========================================================
    // Run
    // ==========================================================
    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Run takes about 130 cycles
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge sys_clk_i);
        arst_n_i <= 1;
        repeat (2) @(posedge sys_clk_i);
        t_reset();
        t_rates();
        t_bits();
        t_path();
        t_fail();
        t_src();
        end_sim();
    end
endmodule

`default_nettype wire
